// File: shared/dbg_pkg.sv
// Constants and carrier types for the debug command interpreter
package dbg_pkg;

    // ------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WR_CTL = 8'h04;
    localparam logic [7:0] CMD_RD_CTL = 8'h05;
    localparam logic [7:0] CMD_WR_PC = 8'h06;
    localparam logic [7:0] CMD_RD_PC = 8'h07;
    localparam logic [7:0] CMD_WR_REG = 8'h08;
    localparam logic [7:0] CMD_RD_REG = 8'h09;
    localparam logic [7:0] CMD_WR_PMEM = 8'h0A;
    localparam logic [7:0] CMD_RD_PMEM = 8'h0B;
    localparam logic [7:0] CMD_WR_DMEM = 8'h0C;
    localparam logic [7:0] CMD_RD_DMEM = 8'h0D;
    localparam logic [7:0] CMD_RD_CRC = 8'h0E;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;

    // ------------------------------------------------------------
    // Fields, reset values, fill patterns
    // ------------------------------------------------------------
    localparam int HALT_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [15:0] FILL_WORD = 16'hFFFF;
    localparam logic [16:0] REG_SIZE_ZERO = 17'h0_0100;
    localparam logic [16:0] MEM_SIZE_ZERO = 17'h1_0000;

    // Flash controller registers writable under read protection
    localparam logic [11:0] FLASH_CTL_LO = 12'hFF8;
    localparam logic [11:0] FLASH_CTL_HI = 12'hFFF;
    // Watchdog status register keeps its read side effect
    localparam logic [11:0] WDT_STAT_ADDR = 12'hFF0;

    // CRC-CCITT
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // ------------------------------------------------------------
    // Memory access carrier
    // ------------------------------------------------------------
    localparam logic [1:0] SPACE_REG = 2'h0;
    localparam logic [1:0] SPACE_PMEM = 2'h1;
    localparam logic [1:0] SPACE_DMEM = 2'h2;

    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] space;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic quiet;
    } mem_req_t;

endpackage

// File: hdl/debug_command_interpreter.sv
// Debug command interpreter: byte command stream to CPU and memory accesses
`timescale 1ns/1ps

// Functional notes
// - Command 04H plus one byte loads control
// - Control bit 7 halts CPU fetch
// - Command 05H returns control register byte
// - 06H loads PC, gated by halt, protect
// - 07H returns PC, FFFFH when gated
// - 08H address bytes, size, data bytes
// - Register writes gated; protect allows flash only
// - 09H returns size bytes of register data
// - Debug register reads are side effect free except watchdog status
// - Gated register reads return FFH bytes
// - 0AH 16-bit address, 16-bit size, data
// - Program writes need unlock, halt, no protect
// - 0BH program read, FFH when gated
// - 0CH data write, discarded when gated
// - 0DH data read, FFH only when running
// - 0EH CRC over program memory, FFFFH running
// - CRC reply comes after memory scan
// - 10H steps one instruction when allowed
// - 11H stuffs opcode byte, then executes
// - 12H sends whole instruction for execution
module debug_command_interpreter #(
    parameter int PMEM_BYTES = 65536 // Program memory bytes covered by CRC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic rx_valid, // Host byte strobe
    input wire logic [7:0] rx_data, // Host byte
    input wire logic tx_ready, // Reply byte taken
    output logic tx_valid, // Reply byte pending
    output logic [7:0] tx_data, // Reply byte
    input wire logic read_protect, // Read protect option enabled
    input wire logic flash_unlocked, // Flash controller unlocked
    input wire logic [15:0] cpu_pc, // Current program counter
    output logic cpu_halt, // CPU fetch halted
    output logic [7:0] ctl_reg, // Debug control register
    output logic pc_load, // Load program counter pulse
    output logic [15:0] pc_value, // Program counter value
    output logic step_pulse, // Step one instruction
    output logic stuff_pulse, // Stuff first byte and step
    output logic [7:0] stuff_opcode, // Stuffed first byte
    output logic exec_valid, // Instruction byte pulse
    output logic exec_first, // Byte is the opcode
    output logic [7:0] exec_byte, // Instruction byte
    input wire logic [2:0] exec_len, // Length decoded from exec_byte
    output dbg_pkg::mem_req_t mem, // Memory request
    input wire logic mem_ack, // Memory access done
    input wire logic [7:0] mem_rdata // Memory read byte
);
    import dbg_pkg::*;

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CMD = 4'b0000,
        ST_ARG = 4'b0001,
        ST_RUN = 4'b0010,
        ST_SEND = 4'b0011,
        ST_WRX = 4'b0100,
        ST_MACK = 4'b0101,
        ST_RREQ = 4'b0110,
        ST_CRC = 4'b0111,
        ST_CRCW = 4'b1000,
        ST_XOP = 4'b1001,
        ST_XBYTE = 4'b1010
    } state_t;

    localparam logic [16:0] CRC_LAST = 17'(PMEM_BYTES - 1);

    state_t state;
    logic [7:0] cmd;
    logic [31:0] args;
    logic [2:0] arg_left;
    logic [16:0] count;
    logic [16:0] crc_addr;
    logic [15:0] crc;
    logic [15:0] resp;
    logic resp_left;
    logic allow;
    logic [2:0] xleft;
    logic halted;
    logic write_ok;
    logic read_ok;
    logic rd_cmd;
    logic [15:0] next_crc;

    function automatic logic [2:0] arg_count(input logic [7:0] c);
        case (c)
            CMD_WR_CTL, CMD_STUFF, CMD_EXEC: arg_count = 3'd1;
            CMD_WR_PC: arg_count = 3'd2;
            CMD_WR_REG, CMD_RD_REG: arg_count = 3'd3;
            CMD_WR_PMEM, CMD_RD_PMEM, CMD_WR_DMEM, CMD_RD_DMEM: arg_count = 3'd4;
            default: arg_count = 3'd0;
        endcase
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] v;
        v = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            v = v[15] ? ({v[14:0], 1'b0} ^ CRC_POLY) : {v[14:0], 1'b0};
        end
        crc_step = v;
    endfunction

    assign halted = ctl_reg[HALT_BIT];
    assign rd_cmd = (cmd == CMD_RD_REG) || (cmd == CMD_RD_PMEM) || (cmd == CMD_RD_DMEM);
    assign next_crc = crc_step(crc, mem_rdata);

    // ------------------------------------------------------------
    // Access gating per byte
    // ------------------------------------------------------------
    // Checked per byte since the address moves and unlock may change mid-burst
    always_comb begin
        write_ok = 1'b0;
        read_ok = 1'b0;
        case (mem.space)
            SPACE_REG: begin
                write_ok = halted && (!read_protect ||
                    (mem.addr[11:0] >= FLASH_CTL_LO && mem.addr[11:0] <= FLASH_CTL_HI));
                read_ok = halted && !read_protect;
            end
            SPACE_PMEM: begin
                write_ok = flash_unlocked && halted && !read_protect;
                read_ok = halted && !read_protect;
            end
            SPACE_DMEM: begin
                write_ok = halted && !read_protect;
                read_ok = halted;
            end
            default: begin
                write_ok = 1'b0;
                read_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Debug control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= CTL_RESET;
        end else if (state == ST_ARG && rx_valid && arg_left == 3'd1 && cmd == CMD_WR_CTL) begin
            // store control byte; protect forbids leaving halt
            ctl_reg <= read_protect ? (rx_data | (ctl_reg & 8'h80)) : rx_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= halted;
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_CMD;
            cmd <= 8'h00;
            args <= 32'h0000_0000;
            arg_left <= 3'd0;
            count <= 17'h0_0000;
            crc_addr <= 17'h0_0000;
            crc <= CRC_INIT;
            resp <= 16'h0000;
            resp_left <= 1'b0;
            allow <= 1'b0;
            xleft <= 3'd0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            pc_load <= 1'b0;
            pc_value <= 16'h0000;
            step_pulse <= 1'b0;
            stuff_pulse <= 1'b0;
            stuff_opcode <= 8'h00;
            exec_valid <= 1'b0;
            exec_first <= 1'b0;
            exec_byte <= 8'h00;
            mem <= '0;
        end else begin
            pc_load <= 1'b0;
            step_pulse <= 1'b0;
            stuff_pulse <= 1'b0;
            exec_valid <= 1'b0;
            exec_first <= 1'b0;
            case (state)
                ST_CMD: begin
                    if (rx_valid) begin
                        cmd <= rx_data;
                        arg_left <= arg_count(rx_data);
                        state <= (arg_count(rx_data) == 3'd0) ? ST_RUN : ST_ARG;
                    end
                end
                ST_ARG: begin
                    if (rx_valid) begin
                        args <= {args[23:0], rx_data};
                        arg_left <= arg_left - 3'd1;
                        if (arg_left == 3'd1) begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    allow <= halted && !read_protect;
                    count <= 17'h0_0000;
                    resp_left <= 1'b0;
                    state <= ST_CMD;
                    case (cmd)
                        CMD_RD_CTL: begin
                            tx_data <= ctl_reg;
                            tx_valid <= 1'b1;
                            state <= ST_SEND;
                        end
                        CMD_WR_PC: begin
                            if (halted && !read_protect) begin
                                pc_load <= 1'b1;
                                pc_value <= args[15:0];
                            end
                        end
                        CMD_RD_PC: begin
                            // PC high byte first or fill
                            resp <= (halted && !read_protect) ? cpu_pc : FILL_WORD;
                            tx_data <= (halted && !read_protect) ? cpu_pc[15:8] : FILL_BYTE;
                            tx_valid <= 1'b1;
                            resp_left <= 1'b1;
                            state <= ST_SEND;
                        end
                        CMD_WR_REG, CMD_RD_REG: begin
                            // upper nibble of address byte ignored
                            mem.space <= SPACE_REG;
                            mem.addr <= {4'h0, args[19:16], args[15:8]};
                            count <= (args[7:0] == 8'h00) ? REG_SIZE_ZERO : {9'h000, args[7:0]};
                            state <= (cmd == CMD_WR_REG) ? ST_WRX : ST_RREQ;
                        end
                        CMD_WR_PMEM, CMD_RD_PMEM, CMD_WR_DMEM, CMD_RD_DMEM: begin
                            mem.space <= (cmd == CMD_WR_PMEM || cmd == CMD_RD_PMEM) ?
                                SPACE_PMEM : SPACE_DMEM;
                            mem.addr <= args[31:16];
                            count <= (args[15:0] == 16'h0000) ? MEM_SIZE_ZERO :
                                {1'b0, args[15:0]};
                            state <= (cmd == CMD_WR_PMEM || cmd == CMD_WR_DMEM) ?
                                ST_WRX : ST_RREQ;
                        end
                        CMD_RD_CRC: begin
                            if (halted) begin
                                crc <= CRC_INIT;
                                crc_addr <= 17'h0_0000;
                                mem.space <= SPACE_PMEM;
                                state <= ST_CRC;
                            end else begin
                                resp <= FILL_WORD;
                                tx_data <= FILL_BYTE;
                                tx_valid <= 1'b1;
                                resp_left <= 1'b1;
                                state <= ST_SEND;
                            end
                        end
                        CMD_STEP: begin
                            step_pulse <= halted && !read_protect;
                        end
                        CMD_STUFF: begin
                            // stuffed opcode, rest from program memory
                            stuff_pulse <= halted && !read_protect;
                            stuff_opcode <= args[7:0];
                        end
                        CMD_EXEC: begin
                            exec_byte <= args[7:0];
                            exec_valid <= halted && !read_protect;
                            exec_first <= 1'b1;
                            state <= ST_XOP;
                        end
                        default: state <= ST_CMD;
                    endcase
                end
                ST_XOP: begin
                    // Bytes are consumed even when gated so framing stays aligned
                    xleft <= (exec_len == 3'd0) ? 3'd0 : exec_len - 3'd1;
                    state <= (exec_len <= 3'd1) ? ST_CMD : ST_XBYTE;
                end
                ST_XBYTE: begin
                    if (rx_valid) begin
                        exec_byte <= rx_data;
                        exec_valid <= allow;
                        xleft <= xleft - 3'd1;
                        if (xleft == 3'd1) begin
                            state <= ST_CMD;
                        end
                    end
                end
                ST_WRX: begin
                    if (rx_valid) begin
                        if (write_ok) begin
                            mem.req <= 1'b1;
                            mem.we <= 1'b1;
                            mem.wdata <= rx_data;
                            mem.quiet <= 1'b1;
                            state <= ST_MACK;
                        end else begin
                            mem.addr <= mem.addr + 16'h0001;
                            count <= count - 17'h0_0001;
                            if (count == 17'h0_0001) begin
                                state <= ST_CMD;
                            end
                        end
                    end
                end
                ST_RREQ: begin
                    if (read_ok) begin
                        mem.req <= 1'b1;
                        mem.we <= 1'b0;
                        // only watchdog status keeps its read effect
                        mem.quiet <= !(mem.space == SPACE_REG && mem.addr[11:0] == WDT_STAT_ADDR);
                        state <= ST_MACK;
                    end else begin
                        tx_data <= FILL_BYTE;
                        tx_valid <= 1'b1;
                        mem.addr <= mem.addr + 16'h0001;
                        count <= count - 17'h0_0001;
                        state <= ST_SEND;
                    end
                end
                ST_MACK: begin
                    if (mem_ack) begin
                        mem.req <= 1'b0;
                        mem.addr <= mem.addr + 16'h0001;
                        count <= count - 17'h0_0001;
                        if (mem.we) begin
                            state <= (count == 17'h0_0001) ? ST_CMD : ST_WRX;
                        end else begin
                            tx_data <= mem_rdata;
                            tx_valid <= 1'b1;
                            state <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        if (rd_cmd && count != 17'h0_0000) begin
                            state <= ST_RREQ;
                        end else if (resp_left) begin
                            tx_data <= resp[7:0];
                            tx_valid <= 1'b1;
                            resp_left <= 1'b0;
                        end else begin
                            state <= ST_CMD;
                        end
                    end
                end
                ST_CRC: begin
                    mem.req <= 1'b1;
                    mem.we <= 1'b0;
                    mem.quiet <= 1'b1;
                    mem.addr <= crc_addr[15:0];
                    state <= ST_CRCW;
                end
                ST_CRCW: begin
                    if (mem_ack) begin
                        // reply only after the last byte
                        mem.req <= 1'b0;
                        crc <= next_crc;
                        crc_addr <= crc_addr + 17'h0_0001;
                        if (crc_addr == CRC_LAST) begin
                            resp <= next_crc;
                            tx_data <= next_crc[15:8];
                            tx_valid <= 1'b1;
                            resp_left <= 1'b1;
                            state <= ST_SEND;
                        end else begin
                            state <= ST_CRC;
                        end
                    end
                end
                default: state <= ST_CMD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence ctl_byte_s;
        state == ST_ARG && cmd == CMD_WR_CTL && rx_valid && arg_left == 3'd1 && !read_protect;
    endsequence

    ctl_store_a: assert property (ctl_byte_s |=> ctl_reg == $past(rx_data))
        else $error("control byte not stored");
    halt_follow_a: assert property (ctl_byte_s |=> ##1 cpu_halt == $past(rx_data[7], 2))
        else $error("halt output wrong");
    ctl_reply_a: assert property (state == ST_RUN && cmd == CMD_RD_CTL |=>
        tx_valid && tx_data == $past(ctl_reg))
        else $error("control reply wrong");
    pc_gate_a: assert property (pc_load |-> $past(halted) && !$past(read_protect))
        else $error("PC loaded while gated");
    pc_fill_a: assert property (state == ST_RUN && cmd == CMD_RD_PC && !halted |=>
        tx_data == FILL_BYTE ##1 resp[7:0] == FILL_BYTE)
        else $error("PC fill missing");
    reg_wr_gate_a: assert property (mem.req && mem.we && mem.space == SPACE_REG |->
        halted && (!read_protect || mem.addr[11:0] >= FLASH_CTL_LO))
        else $error("register write leaked");
    quiet_read_a: assert property (mem.req && !mem.we && mem.space == SPACE_REG &&
        mem.addr[11:0] != WDT_STAT_ADDR |-> mem.quiet)
        else $error("register read not quiet");
    prog_wr_gate_a: assert property (mem.req && mem.we && mem.space == SPACE_PMEM |->
        flash_unlocked && halted && !read_protect)
        else $error("program write leaked");
    step_gate_a: assert property (step_pulse |-> $past(halted && !read_protect))
        else $error("step while gated");
    addr_step_a: assert property (state == ST_MACK && mem_ack |=>
        mem.addr == $past(mem.addr) + 16'h0001)
        else $error("address did not advance");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");

endmodule // debug_command_interpreter

// File: test/debug_host_model.sv
// Behavioural debug host driving the byte stream
`timescale 1ns/1ps
module debug_host_model (
    input wire logic clk_sys, // System clock
    input wire logic tx_valid, // Reply pending
    input wire logic [7:0] tx_data, // Reply byte
    output logic rx_valid, // Byte strobe
    output logic [7:0] rx_data, // Byte to device
    output logic tx_ready // Reply taken
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // one strobe per byte, operands high byte first
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_data <= ~b;
    endtask
    // waits for the reply instead of a fixed delay
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (tx_valid !== 1'b1 && n < 500);
        // A reply that never came reads as unknown so every compare trips
        b = (tx_valid === 1'b1) ? tx_data : 8'hxx;
        @(posedge clk_sys);
        tx_ready <= 1'b1;
        @(posedge clk_sys);
        tx_ready <= 1'b0;
    endtask
endmodule // debug_host_model

// File: test/debug_command_interpreter_test.sv
// Self-checking bench for the debug command interpreter
`timescale 1ns/1ps
module debug_command_interpreter_test;
    import dbg_pkg::*;
    logic clk_sys, rst_n, rx_valid, tx_ready, tx_valid, read_protect, mem_ack, cpu_halt, pc_load;
    logic flash_unlocked, step_pulse, stuff_pulse, exec_valid, exec_first;
    logic [2:0] exec_len;
    logic [7:0] rx_data, tx_data, mem_rdata, b, ctl_reg, stuff_opcode, exec_byte, exec_op, wr_data;
    logic [15:0] cpu_pc, pc_value, pc_seen, wr_addr;
    int step_seen = 0;
    int stuff_seen = 0;
    int exec_seen = 0;
    int wr_seen = 0;
    mem_req_t mem;
    int bad_count = 0;
    int tests_run = 0;
    debug_host_model host (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
    debug_command_interpreter #(.PMEM_BYTES(16)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .read_protect(read_protect), .flash_unlocked(flash_unlocked),
        .cpu_pc(cpu_pc), .cpu_halt(cpu_halt), .ctl_reg(ctl_reg), .pc_load(pc_load),
        .pc_value(pc_value), .step_pulse(step_pulse), .stuff_pulse(stuff_pulse),
        .stuff_opcode(stuff_opcode), .exec_valid(exec_valid), .exec_first(exec_first),
        .exec_byte(exec_byte), .exec_len(exec_len), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Memory answers one cycle after a request, data tied to the address
    always @(posedge clk_sys) begin
        mem_ack <= mem.req && !mem_ack;
        mem_rdata <= mem.addr[7:0] ^ 8'h5A;
        if (pc_load) pc_seen <= pc_value;
        if (step_pulse) step_seen <= step_seen + 1;
        if (stuff_pulse) stuff_seen <= stuff_seen + 1;
        if (exec_valid) exec_seen <= exec_seen + 1;
        if (exec_valid && exec_first) exec_op <= exec_byte;
        if (mem.req && mem.we && mem_ack) begin
            wr_seen <= wr_seen + 1;
            wr_addr <= mem.addr;
            wr_data <= mem.wdata;
        end
    end
    // Reference CRC over the modelled program memory (16 bytes)
    function automatic logic [15:0] crc_ref();
        logic [15:0] c;
        c = CRC_INIT;
        for (int a = 0; a < 16; a++) begin
            c = c ^ {8'(a) ^ 8'h5A, 8'h00};
            for (int i = 0; i < 8; i++) c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic rd2(input logic [15:0] exp);
        host.recv(b);
        chk({8'h00, b}, {8'h00, exp[15:8]});
        host.recv(b);
        chk({8'h00, b}, {8'h00, exp[7:0]});
    endtask
    task automatic reg_read(input logic [15:0] exp);
        host.send(CMD_RD_REG);
        host.send(8'h01);
        host.send(8'h23);
        host.send(8'h02);
        rd2(exp);
    endtask
    task automatic mem_cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
        host.send(c);
        host.send(a[15:8]);
        host.send(a[7:0]);
        host.send(n[15:8]);
        host.send(n[7:0]);
    endtask
    // Instruction bytes need a gap after the opcode while its length is decoded
    task automatic exec_cmds;
        host.send(CMD_STEP);
        host.send(CMD_STUFF);
        host.send(8'h3C);
        host.send(CMD_EXEC);
        host.send(8'hA1);
        repeat (2) @(posedge clk_sys);
        host.send(8'hB2);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic protect_checks;
        read_protect <= 1'b1;
        reg_read(FILL_WORD);
        mem_cmd(CMD_RD_DMEM, 16'h0040, 16'h0001);
        host.recv(b);
        chk({8'h00, b}, {8'h00, 8'h40 ^ 8'h5A});
        mem_cmd(CMD_RD_PMEM, 16'h0040, 16'h0001);
        host.recv(b);
        chk({8'h00, b}, {8'h00, FILL_BYTE});
        host.send(CMD_WR_CTL);
        host.send(8'h00);
        @(negedge clk_sys);
        chk({8'h00, ctl_reg}, 16'h0080);
        host.send(CMD_WR_PC);
        host.send(8'h11);
        host.send(8'h22);
        repeat (4) @(posedge clk_sys);
        chk(pc_seen, 16'hABCD);
        exec_cmds;
        read_protect <= 1'b0;
    endtask
    // Each write waits out the memory handshake before the next byte
    task automatic write_checks;
        mem_cmd(CMD_WR_PMEM, 16'h0010, 16'h0001);
        host.send(8'h77);
        repeat (4) @(posedge clk_sys);
        chk(16'(wr_seen), 16'h0000);
        flash_unlocked <= 1'b1;
        mem_cmd(CMD_WR_PMEM, 16'h0010, 16'h0001);
        host.send(8'h77);
        repeat (4) @(posedge clk_sys);
        chk({wr_data, wr_addr[7:0]}, 16'h7710);
        mem_cmd(CMD_WR_DMEM, 16'h0020, 16'h0001);
        host.send(8'h55);
        repeat (4) @(posedge clk_sys);
        chk(16'(wr_seen), 16'h0002);
        chk({wr_data, wr_addr[7:0]}, 16'h5520);
    endtask
    task automatic exec_checks;
        exec_cmds;
        chk(16'(step_seen), 16'h0001);
        chk({8'(stuff_seen), stuff_opcode}, 16'h013C);
        chk(16'(exec_seen), 16'h0002);
        chk({exec_op, exec_byte}, 16'hA1B2);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        complete_run;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        read_protect = 1'b0;
        flash_unlocked = 1'b0;
        exec_len = 3'd2;
        cpu_pc = 16'h1234;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        host.send(CMD_RD_CRC);
        rd2(FILL_WORD);
        host.send(CMD_RD_PC);
        rd2(FILL_WORD);
        host.send(CMD_WR_CTL);
        host.send(8'h80);
        host.send(CMD_RD_CTL);
        host.recv(b);
        chk({8'h00, b}, 16'h0080);
        chk({15'h0000, cpu_halt}, 16'h0001);
        host.send(CMD_RD_PC);
        rd2(16'h1234);
        host.send(CMD_WR_PC);
        host.send(8'hAB);
        host.send(8'hCD);
        repeat (4) @(posedge clk_sys);
        chk(pc_seen, 16'hABCD);
        reg_read({8'h23 ^ 8'h5A, 8'h24 ^ 8'h5A});
        protect_checks;
        write_checks;
        exec_checks;
        host.send(CMD_RD_CRC);
        rd2(crc_ref());
        complete_run;
    end
endmodule // debug_command_interpreter_test
